/* File: logic/timer_unit_pkg.sv */
// Constants, register map and carrier types for the triple timer unit
package timer_unit_pkg;

  // Register offsets in the peripheral control block
  localparam logic [7:0] T0_COUNT_OFS = 8'h50;
  localparam logic [7:0] T0_LIMIT_A_OFS = 8'h52;
  localparam logic [7:0] T0_LIMIT_B_OFS = 8'h54;
  localparam logic [7:0] T0_CTL_OFS = 8'h56;
  localparam logic [7:0] T1_COUNT_OFS = 8'h58;
  localparam logic [7:0] T1_LIMIT_A_OFS = 8'h5A;
  localparam logic [7:0] T1_LIMIT_B_OFS = 8'h5C;
  localparam logic [7:0] T1_CTL_OFS = 8'h5E;
  localparam logic [7:0] T2_COUNT_OFS = 8'h60;
  localparam logic [7:0] T2_LIMIT_A_OFS = 8'h62;
  localparam logic [7:0] T2_CTL_OFS = 8'h66;

  // Mode/control field positions
  localparam int unsigned RUN_EN_BIT = 15;
  localparam int unsigned WRITE_GUARD_BIT = 14;
  localparam int unsigned IRQ_EN_BIT = 13;
  localparam int unsigned ACTIVE_LIMIT_BIT = 12;
  localparam int unsigned LIMIT_HIT_BIT = 5;
  localparam int unsigned EDGE_RESTART_BIT = 4;
  localparam int unsigned PRESCALE_BIT = 3;
  localparam int unsigned OUTSIDE_CLOCK_BIT = 2;
  localparam int unsigned DUAL_LIMIT_BIT = 1;
  localparam int unsigned REPEAT_RUN_BIT = 0;

  // Reset values
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;

  // Timing: one service slot per timer in every group of four clocks at full rate, of four ticks in power save
  localparam int unsigned SERVICE_PERIOD = 4;
  localparam int unsigned RESPONSE_MAX_CYCLES = 6;

  // Service slot, one-hot
  typedef enum logic [3:0] {
    PH_T0 = 4'h1,
    PH_T1 = 4'h2,
    PH_T2 = 4'h4,
    PH_SPARE = 4'h8
  } phase_t;

  // Stored mode/control bits of one timer
  typedef struct packed {
    logic en;
    logic irq_en;
    logic active_limit_flag;
    logic mc;
    logic edge_restart_bit;
    logic pre;
    logic outside_clock_bit;
    logic dual_limit_bit;
    logic repeat_run_bit;
  } ctl_t;

  // One register access from the processor side
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

/* File: logic/triple_timer_unit.sv */
// Three 16-bit timers with compare; gating, external clock, prescale and pulse measurement on timers 0 and 1
`timescale 1ns/1ps
`default_nettype none

module triple_timer_unit (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Power-save rate: while power_save_i is high, slots advance on ticks only
  input wire logic power_save_i,
  input wire logic power_save_tick_i,
  // Register access
  input wire timer_unit_pkg::reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_sel_o,
  // Timer pins and pulse measurement
  input wire logic timer0_input_pin_i,
  input wire logic timer1_input_pin_i,
  input wire logic pulse_input_pin_i,
  input wire logic pulse_measure_mode_i,
  output logic timer0_output_pin_o,
  output logic timer1_output_pin_o,
  output logic [1:0] input_released_o,
  // Requests
  input wire logic [2:0] irq_ack_i,
  output logic [2:0] irq_req_o,
  output logic timer2_dma_req_o
);

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register state
  logic [15:0] count [3];
  logic [15:0] lim_a [3];
  logic [15:0] lim_b [3];
  timer_unit_pkg::ctl_t ctl [3];
  timer_unit_pkg::phase_t phase;
  logic [2:0] out_q;
  logic [2:0] edge_pend;
  logic [2:0] in_prev;
  logic [1:0] pin_q;
  logic pulse_q;
  logic t2_evt;
  logic [2:0] irq_pend;
  logic dma_q;

  // Pack stored control bits into the readable word; guard always reads zero
  function automatic logic [15:0] ctl_pack(input timer_unit_pkg::ctl_t c, input logic full);
    logic [15:0] w;
    w = 16'h0000;
    w[timer_unit_pkg::RUN_EN_BIT] = c.en;
    w[timer_unit_pkg::IRQ_EN_BIT] = c.irq_en;
    w[timer_unit_pkg::LIMIT_HIT_BIT] = c.mc;
    w[timer_unit_pkg::REPEAT_RUN_BIT] = c.repeat_run_bit;
    if (full) begin
      w[timer_unit_pkg::ACTIVE_LIMIT_BIT] = c.active_limit_flag;
      w[timer_unit_pkg::EDGE_RESTART_BIT] = c.edge_restart_bit;
      w[timer_unit_pkg::PRESCALE_BIT] = c.pre;
      w[timer_unit_pkg::OUTSIDE_CLOCK_BIT] = c.outside_clock_bit;
      w[timer_unit_pkg::DUAL_LIMIT_BIT] = c.dual_limit_bit;
    end
    return w;
  endfunction

  // Address decode
  wire [15:0] wdata = reg_req_i.wdata;
  wire [7:0] addr = reg_req_i.addr;
  wire [2:0] sel_cnt = {addr == timer_unit_pkg::T2_COUNT_OFS, addr == timer_unit_pkg::T1_COUNT_OFS,
                        addr == timer_unit_pkg::T0_COUNT_OFS};
  wire [2:0] sel_lima = {addr == timer_unit_pkg::T2_LIMIT_A_OFS, addr == timer_unit_pkg::T1_LIMIT_A_OFS,
                         addr == timer_unit_pkg::T0_LIMIT_A_OFS};
  wire [2:0] sel_limb = {1'b0, addr == timer_unit_pkg::T1_LIMIT_B_OFS, addr == timer_unit_pkg::T0_LIMIT_B_OFS};
  wire [2:0] sel_ctl = {addr == timer_unit_pkg::T2_CTL_OFS, addr == timer_unit_pkg::T1_CTL_OFS,
                        addr == timer_unit_pkg::T0_CTL_OFS};
  wire [2:0] wr_cnt = sel_cnt & {3{reg_req_i.wr}};
  wire [2:0] wr_lima = sel_lima & {3{reg_req_i.wr}};
  wire [2:0] wr_limb = sel_limb & {3{reg_req_i.wr}};
  wire [2:0] wr_ctl = sel_ctl & {3{reg_req_i.wr}};
  wire guard = wdata[timer_unit_pkg::WRITE_GUARD_BIT];
  assign reg_sel_o = |{sel_cnt, sel_lima, sel_limb, sel_ctl};

  // Slot advance: full rate normally, power-save tick rate otherwise
  wire adv = !power_save_i || power_save_tick_i;

  // Effective timer inputs; pulse mode steers one input to both timers
  wire [2:0] eff_in = pulse_measure_mode_i ? {1'b0, !pulse_q, pulse_q} : {1'b0, pin_q};
  wire [2:0] in_rise = eff_in & ~in_prev;
  assign input_released_o = {!ctl[1].outside_clock_bit || pulse_measure_mode_i, !ctl[0].outside_clock_bit || pulse_measure_mode_i};

  // Per-timer event, compare and next-state decisions
  logic [2:0] serve;
  logic [2:0] tick;
  logic [2:0] hit;
  logic [2:0] retrig;
  logic [2:0] stop;
  logic [2:0] next_riu;
  logic [15:0] lim [3];
  logic [15:0] inc [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      serve[i] = adv && phase[i];
      lim[i] = ctl[i].active_limit_flag ? lim_b[i] : lim_a[i];
      inc[i] = count[i] + 16'h0001;
      if (i == 2) begin
        retrig[i] = 1'b0;
        tick[i] = serve[i] && ctl[i].en;
      end else if (ctl[i].outside_clock_bit) begin
        retrig[i] = 1'b0;
        tick[i] = serve[i] && ctl[i].en && edge_pend[i];
      end else begin
        retrig[i] = serve[i] && ctl[i].en && ctl[i].edge_restart_bit && edge_pend[i];
        tick[i] = serve[i] && ctl[i].en && !retrig[i] && (ctl[i].edge_restart_bit || eff_in[i])
                  && (!ctl[i].pre || t2_evt);
      end
      hit[i] = tick[i] && (inc[i] == lim[i]);
      next_riu[i] = ctl[i].dual_limit_bit && (hit[i] ? !ctl[i].active_limit_flag : ctl[i].active_limit_flag);
      stop[i] = hit[i] && !ctl[i].repeat_run_bit && (!ctl[i].dual_limit_bit || ctl[i].active_limit_flag);
    end
  end

  // Pin sampling and event latches; a new edge wins over the service clear
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 2'b00;
      pulse_q <= 1'b0;
      in_prev <= 3'b000;
      edge_pend <= 3'b000;
    end else begin
      pin_q <= {timer1_input_pin_i, timer0_input_pin_i};
      pulse_q <= pulse_input_pin_i;
      in_prev <= eff_in;
      edge_pend <= in_rise | (edge_pend & ~serve);
    end
  end

  // Service slot rotation, one slot per timer in each group of four
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= timer_unit_pkg::PH_T0;
    end else if (adv) begin
      case (phase)
        timer_unit_pkg::PH_T0: phase <= timer_unit_pkg::PH_T1;
        timer_unit_pkg::PH_T1: phase <= timer_unit_pkg::PH_T2;
        timer_unit_pkg::PH_T2: phase <= timer_unit_pkg::PH_SPARE;
        default: phase <= timer_unit_pkg::PH_T0;
      endcase
    end
  end

  // Timer 2 hit held for one whole round as the prescale event
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      t2_evt <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      if (serve[2]) begin
        t2_evt <= hit[2];
      end
      dma_q <= hit[2];
    end
  end

  // Count and limit registers; a software write wins over the hardware update
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        count[i] <= timer_unit_pkg::COUNT_RESET;
        lim_a[i] <= timer_unit_pkg::LIMIT_RESET;
        lim_b[i] <= timer_unit_pkg::LIMIT_RESET;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_cnt[i]) begin
          count[i] <= wdata;
        end else if (hit[i] || retrig[i]) begin
          count[i] <= timer_unit_pkg::COUNT_RESET;
        end else if (tick[i]) begin
          count[i] <= inc[i];
        end
        if (wr_lima[i]) begin
          lim_a[i] <= wdata;
        end
        if (wr_limb[i]) begin
          lim_b[i] <= wdata;
        end
      end
    end
  end

  // Control registers: guarded enable, sticky limit-hit flag, active-limit flag
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        ctl[i] <= timer_unit_pkg::ctl_t'(timer_unit_pkg::CTL_RESET[8:0]);
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_ctl[i] && guard) begin
          ctl[i].en <= wdata[timer_unit_pkg::RUN_EN_BIT];
        end else if (stop[i]) begin
          ctl[i].en <= 1'b0;
        end
        ctl[i].mc <= hit[i] || (ctl[i].mc && !(wr_ctl[i] && !wdata[timer_unit_pkg::LIMIT_HIT_BIT]));
        ctl[i].active_limit_flag <= next_riu[i];
        if (wr_ctl[i]) begin
          ctl[i].irq_en <= wdata[timer_unit_pkg::IRQ_EN_BIT];
          ctl[i].repeat_run_bit <= wdata[timer_unit_pkg::REPEAT_RUN_BIT];
          if (i < 2) begin
            ctl[i].edge_restart_bit <= wdata[timer_unit_pkg::EDGE_RESTART_BIT];
            ctl[i].pre <= wdata[timer_unit_pkg::PRESCALE_BIT];
            ctl[i].outside_clock_bit <= wdata[timer_unit_pkg::OUTSIDE_CLOCK_BIT];
            ctl[i].dual_limit_bit <= wdata[timer_unit_pkg::DUAL_LIMIT_BIT];
          end
        end
      end
    end
  end

  // Interrupt requests: set at each limit, held until acknowledged
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        irq_pend[i] <= (hit[i] && ctl[i].irq_en) || (irq_pend[i] && !irq_ack_i[i]);
      end
    end
  end
  assign irq_req_o = irq_pend;
  assign timer2_dma_req_o = dma_q;

  // Output waveform: low pulse after a hit, or active-limit level when alternating
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 3'b111;
    end else begin
      for (int i = 0; i < 3; i++) begin
        out_q[i] <= ctl[i].dual_limit_bit ? !next_riu[i] : !hit[i];
      end
    end
  end
  assign timer0_output_pin_o = out_q[0];
  assign timer1_output_pin_o = out_q[1];

  // Read data, registered one cycle after the read strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      if (sel_cnt[i]) begin
        rd_mux = count[i];
      end else if (sel_lima[i]) begin
        rd_mux = lim_a[i];
      end else if (sel_limb[i]) begin
        rd_mux = lim_b[i];
      end else if (sel_ctl[i]) begin
        rd_mux = ctl_pack(ctl[i], i < 2);
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  count_wrap_a: assert property ((hit[0] && !wr_cnt[0]) |=> count[0] == 16'h0000)
    else $error("count not cleared on limit");
  low_pulse_a: assert property ((hit[0] && !ctl[0].dual_limit_bit && !wr_ctl[0]) |=> !timer0_output_pin_o ##1 timer0_output_pin_o)
    else $error("single-limit low pulse wrong");
  alt_level_a: assert property ((ctl[1].dual_limit_bit && !wr_ctl[1]) |=> timer1_output_pin_o == !ctl[1].active_limit_flag)
    else $error("alternating output level wrong");
  service_gap_a: assert property (serve[0] |=> !serve[0] [*3])
    else $error("timer serviced more than once per four clocks");
  guard_hold_a: assert property ((wr_ctl[0] && !guard && !hit[0]) |=> ctl[0].en == $past(ctl[0].en))
    else $error("run enable changed without guard");
  hit_flag_a: assert property (hit[1] |=> ctl[1].mc)
    else $error("limit-hit flag not set");
  flag_sticky_a: assert property ((ctl[1].mc && !(wr_ctl[1] && !wdata[timer_unit_pkg::LIMIT_HIT_BIT])) |=> ctl[1].mc)
    else $error("limit-hit flag lost");
  one_shot_a: assert property ((hit[0] && !ctl[0].repeat_run_bit && !ctl[0].dual_limit_bit && !wr_ctl[0] && !wr_cnt[0]) |=> !ctl[0].en && count[0] == 16'h0000)
    else $error("one-shot timer kept running");
  irq_hold_a: assert property ((irq_req_o[0] && !irq_ack_i[0]) |=> irq_req_o[0])
    else $error("pending request dropped");
  restart_edge_a: assert property ((retrig[0] && !wr_cnt[0]) |=> count[0] == 16'h0000)
    else $error("edge restart did not clear count");

endmodule

`default_nettype wire

/* File: sim/pin_model.sv */
// Pin-side model: gate levels, external clock bursts and the pulse line
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock, reset and bench control
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] level_i,
  input wire logic pulse_level_i,
  input wire logic [3:0] burst_i,
  input wire logic go_i,
  // Pins towards the timer unit
  output logic timer0_input_pin_o,
  output logic timer1_input_pin_o,
  output logic pulse_input_pin_o
);
  logic [6:0] left;
  // Burst counter; pin toggles every four clocks, half the fastest edge rate a timer takes
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      left <= 7'h00;
    end else if (go_i) begin
      left <= {burst_i, 3'h0};
    end else if (left != 7'h00) begin
      left <= left - 7'h01;
    end
  end
  // Burst pattern overrides the gate level on pin 0
  assign timer0_input_pin_o = (left != 7'h00) ? left[2] : level_i[0];
  assign timer1_input_pin_o = level_i[1];
  assign pulse_input_pin_o = pulse_level_i;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the triple timer unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] K0 = timer_unit_pkg::T0_COUNT_OFS;
  localparam logic [7:0] A0 = timer_unit_pkg::T0_LIMIT_A_OFS;
  localparam logic [7:0] B0 = timer_unit_pkg::T0_LIMIT_B_OFS;
  localparam logic [7:0] C0 = timer_unit_pkg::T0_CTL_OFS;
  localparam logic [7:0] K1 = timer_unit_pkg::T1_COUNT_OFS;
  localparam logic [7:0] A1 = timer_unit_pkg::T1_LIMIT_A_OFS;
  localparam logic [7:0] C1 = timer_unit_pkg::T1_CTL_OFS;
  localparam logic [7:0] A2 = timer_unit_pkg::T2_LIMIT_A_OFS;
  localparam logic [7:0] C2 = timer_unit_pkg::T2_CTL_OFS;
  logic ref_clk_i, resetn_i, ps, tick, out0, out1, dma, pmode, sel, pin0, pin1, pinp, plvl, go;
  timer_unit_pkg::reg_req_t req;
  logic [15:0] rdata, d;
  logic [1:0] rel, lvl;
  logic [2:0] ack, irq;
  logic [3:0] burst, ev;
  int errors, n_tests, i;
  // Events a bounded wait can look for
  assign ev = {dma, irq[0], out0, ~out0};
  triple_timer_unit triple_timer_unit_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .power_save_i(ps), .power_save_tick_i(tick),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_sel_o(sel),
    .timer0_input_pin_i(pin0), .timer1_input_pin_i(pin1), .pulse_input_pin_i(pinp),
    .pulse_measure_mode_i(pmode), .timer0_output_pin_o(out0), .timer1_output_pin_o(out1),
    .input_released_o(rel), .irq_ack_i(ack), .irq_req_o(irq), .timer2_dma_req_o(dma)
  );
  pin_model pin_model_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .level_i(lvl), .pulse_level_i(plvl),
    .burst_i(burst), .go_i(go), .timer0_input_pin_o(pin0), .timer1_input_pin_o(pin1),
    .pulse_input_pin_o(pinp)
  );
  // Clock, 25 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task tally_and_finish();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task ok(input string n, input logic b);
    chk(n, 16'h0001, {15'h0000, b});
  endtask
  // Register write: strobe for one edge, released at the next falling edge
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge ref_clk_i);
    req = '{a, 1'b1, 1'b0, v};
    @(negedge ref_clk_i);
    req.wr = 1'b0;
  endtask
  // Register read: data taken at the falling edge after the sampling edge
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge ref_clk_i);
    req = '{a, 1'b0, 1'b1, 16'h0000};
    @(negedge ref_clk_i);
    v = rdata;
    req.rd = 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e, input string n);
    rd(a, d);
    chk(n, e, d);
  endtask
  task hold(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Bounded wait for one event bit
  task wait_ev(input int b, input string n);
    for (i = 0; i < 400 && ev[b] !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 400) begin
      errors++;
      $display("wrong value %s exp 1 got 0", n);
      tally_and_finish();
    end
  endtask
  initial begin
    resetn_i = 1'b0;
    req = '0;
    {ps, tick, pmode, plvl, go} = 5'h00;
    ack = 3'h0;
    lvl = 2'h3;
    burst = 4'h0;
    errors = 0;
    n_tests = 0;
    hold(3);
    resetn_i = 1'b1;
    hold(3);
    // Reset values, guard, read-only and unstored bits
    rc(C0, 16'h0000, "t0 ctl");
    rc(C1, 16'h0000, "t1 ctl");
    rc(C2, 16'h0000, "t2 ctl");
    ok("mapped sel", sel === 1'b1);
    rc(8'h40, 16'h0000, "unmapped");
    ok("unmapped sel", sel === 1'b0);
    wr(C0, 16'h9001);
    rc(C0, 16'h0001, "no guard");
    wr(C2, 16'hE03F);
    rc(C2, 16'hA001, "t2 bits");
    wr(C2, 16'h4000);
    $display("test registers done");
    // Single limit: count wraps, short low pulse, sticky hit flag
    wr(A0, 16'h0003);
    wr(C0, 16'hC001);
    for (int k = 0; k < 8; k++) begin
      rd(K0, d);
      ok("below limit", d < 16'h0003);
    end
    wait_ev(0, "out0 low");
    hold(1);
    chk("out0 pulse", 16'h0001, {15'h0000, out0});
    wait_ev(0, "out0 low");
    rc(C0, 16'h8021, "hit flag");
    wr(C0, 16'h4001);
    wr(C0, 16'h0001);
    rc(C0, 16'h0001, "flag cleared");
    // One-shot run halts and drops the enable
    wr(K0, 16'h0000);
    wr(A0, 16'h0002);
    wr(C0, 16'hC000);
    wait_ev(0, "one shot");
    hold(10);
    rc(C0, 16'h0020, "one shot ctl");
    rc(K0, 16'h0000, "one shot cnt");
    $display("test single limit done");
    // Full range at quarter rate, power save, gate and restart
    wr(A0, 16'h0000);
    wr(C0, 16'hC001);
    hold(40);
    rd(K0, d);
    ok("rate", d >= 16'h0009 && d <= 16'h000C);
    ps = 1'b1;
    rd(K0, d);
    hold(20);
    rc(K0, d, "power save");
    ps = 1'b0;
    lvl[0] = 1'b0;
    hold(8);
    rd(K0, d);
    hold(20);
    rc(K0, d, "gated");
    wr(C0, 16'hC011);
    lvl[0] = 1'b1;
    hold(8);
    rd(K0, d);
    ok("restart", d < 16'h0004);
    $display("test counting done");
    // External clock counts five pin pulses
    lvl[0] = 1'b0;
    wr(C0, 16'hC005);
    wr(K0, 16'h0000);
    ok("pin taken", rel[0] === 1'b0);
    burst = 4'h5;
    go = 1'b1;
    hold(1);
    go = 1'b0;
    hold(52);
    rc(K0, 16'h0005, "ext count");
    wr(C0, 16'h4000);
    ok("pin free", rel[0] === 1'b1);
    lvl[0] = 1'b1;
    // Dual limits: A=2 high 8 cycles, B=5 low 20 cycles
    wr(A0, 16'h0002);
    wr(B0, 16'h0005);
    wr(K0, 16'h0000);
    wr(C0, 16'hC003);
    wait_ev(1, "out0 high");
    wait_ev(0, "out0 low");
    rc(C0, 16'h9023, "limit b");
    d = 16'h0000;
    for (int k = 0; k < 56; k++) begin
      @(negedge ref_clk_i);
      d = d + {15'h0000, out0};
    end
    chk("high cycles", 16'h0010, d);
    $display("test dual limit done");
    // Interrupt request survives disable, cleared by acknowledge
    wr(C0, 16'h4000);
    wr(K0, 16'h0000);
    wr(A0, 16'h0003);
    wr(C0, 16'hE001);
    wait_ev(2, "irq");
    wr(C0, 16'h4000);
    hold(4);
    ok("irq held", irq[0] === 1'b1);
    ack = 3'h1;
    hold(1);
    ack = 3'h0;
    hold(1);
    ok("irq clear", irq[0] === 1'b0);
    // Timer 2 request pulse and prescaling of timer 1
    wr(A2, 16'h0003);
    wr(A1, 16'h0000);
    wr(C2, 16'hC001);
    wr(C1, 16'hC009);
    wait_ev(3, "dma");
    hold(1);
    ok("dma pulse", dma === 1'b0);
    hold(60);
    rd(K1, d);
    ok("prescale", d >= 16'h0004 && d <= 16'h0007);
    $display("test timer2 done");
    // Pulse measurement: line held high, timer 0 counts and timer 1 does not
    wr(C1, 16'h4000);
    wr(K1, 16'h0000);
    wr(A0, 16'h0000);
    wr(K0, 16'h0000);
    plvl = 1'b1;
    pmode = 1'b1;
    lvl = 2'h0;
    wr(C0, 16'hC001);
    wr(C1, 16'hC001);
    hold(40);
    ok("pins free", rel === 2'h3);
    ok("out1 idle", out1 === 1'b1);
    rc(K1, 16'h0000, "low timer");
    rd(K0, d);
    ok("high timer", d >= 16'h0008);
    $display("test pulse measure done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
